// ===== hdl/sio_top.sv
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
// Summary of operation
// R1 - unit disable only frees pins, shifting continues
// R2 - buffer write while disabled still shifts internally
// R3 - async transmit stopped by transmit enable
// R4 - async receive stopped by receive enable
// R5 - ready output needs receive, ready, transmit enables
// R6 - both enables cleared resets transmit and receive
// R7 - shift-complete falls 0.5 to 1.5 clocks late
// R8 - external clock: transmit enable set while high
// R9 - external clock: buffer written while high
// R10 - transmit request set on chosen flag rising
// R11 - transmit enable sets empty and complete flags
// R12 - enable transmit, clear request, then enable interrupt
// R13 - synchronous mode clears both enables together
module sio_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // serial pins
   output logic txd_out,
   output logic txd_oe,
   input wire logic rxd_in,
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe,
   output logic receiver_ready_pin_n,
   output logic receiver_ready_pin_oe,
   // interrupt
   output logic irq
);
   logic [6:0] ctrl;
   logic [15:0] baud;
   logic [2:0] irq_stat, irq_en;
   logic [31:0] aw_data;
   logic [7:0] aw_addr;
   logic aw_have, w_have;
   // pin synchronisers
   logic [1:0] rxd_s, sclk_s;
   logic sclk_d, rxd_d;
   always_ff @(posedge aclk) begin
      rxd_s <= {rxd_s[0], rxd_in};
      sclk_s <= {sclk_s[0], sclk_in};
      sclk_d <= sclk_s[1];
      rxd_d <= rxd_s[1];
   end
   wire tx_en = ctrl[sio_pkg::CTRL_TX_EN];
   wire rx_en = ctrl[sio_pkg::CTRL_RX_EN];
   wire sio_en = ctrl[sio_pkg::CTRL_SIO_EN];
   wire sync_mode = ctrl[sio_pkg::CTRL_SYNC];
   wire ext_clk = ctrl[sio_pkg::CTRL_EXT_CLK] & sync_mode;
   // baud divider gives shift ticks; internal sync clock toggles per half bit
   logic [15:0] div;
   logic int_clk;
   wire div_hit = (div == baud);
   wire int_tick = div_hit & int_clk;
   wire sclk_fall = sclk_d & ~sclk_s[1];
   wire sclk_rise = ~sclk_d & sclk_s[1];
   wire shift_tick = ext_clk ? sclk_fall : int_tick;
   // sync receive shares the transmit clock, so it runs only while tx_en is on (see R13)
   wire sample_tick = ext_clk ? sclk_rise : (div_hit & ~int_clk);
   // an external clock is phased by the partner, so only the internal one needs the half edge
   wire half_tick = ext_clk || (div_hit && !int_clk);
   always_ff @(posedge aclk) begin
      if (!aresetn || !(tx_en || rx_en)) begin
         div <= 16'h0000;
         int_clk <= 1'b1;
      end else begin
         div <= div_hit ? 16'h0000 : div + 16'h0001;
         if (div_hit) int_clk <= ~int_clk;
      end
   end
   // axi write path
   wire wr_fire = aw_have && w_have && !s_axi_bvalid;
   assign s_axi_awready = !aw_have;
   assign s_axi_wready = !w_have;
   wire wr_known = aw_addr == sio_pkg::ADDR_CTRL || aw_addr == sio_pkg::ADDR_TXBUF ||
                   aw_addr == sio_pkg::ADDR_BAUD || aw_addr == sio_pkg::ADDR_IRQ_EN ||
                   aw_addr == sio_pkg::ADDR_IRQ_CLR;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire wr_ctrl = wr_fire && aw_addr == sio_pkg::ADDR_CTRL && w_strb[0];
   // a buffer write is accepted regardless of the pin enable (see R2)
   wire wr_txbuf = wr_fire && aw_addr == sio_pkg::ADDR_TXBUF && w_strb[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sio_pkg::RESP_OKAY;
         ctrl <= sio_pkg::CTRL_RESET;
         baud <= sio_pkg::BAUD_RESET;
         irq_en <= 3'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? sio_pkg::RESP_OKAY : sio_pkg::RESP_SLVERR;
            if (wr_ctrl) ctrl <= w_data[6:0];
            if (aw_addr == sio_pkg::ADDR_BAUD) begin
               if (w_strb[0]) baud[7:0] <= w_data[7:0];
               if (w_strb[1]) baud[15:8] <= w_data[15:8];
            end
            if (aw_addr == sio_pkg::ADDR_IRQ_EN && w_strb[0]) irq_en <= w_data[2:0];
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // transmitter
   logic tx_empty, tx_done, tx_line;
   sio_tx u_tx (
      .aclk(aclk),
      .aresetn(aresetn),
      .tx_en(tx_en), // see R3 see R6 see R11
      .sync_mode(sync_mode),
      .shift_tick(shift_tick),
      .half_tick(half_tick),
      .load(wr_txbuf && tx_en),
      .load_data(w_data[7:0]),
      .buf_empty(tx_empty),
      .shift_done(tx_done),
      .tx_line(tx_line)
   );
   // receiver
   logic [7:0] rx_buf, rx_sh;
   logic [3:0] rx_cnt;
   logic rx_busy, rx_full, frame_err, overrun, rx_ev, err_ev;
   wire rd_rxbuf;
   wire rx_run = rx_en && (!sync_mode || tx_en);
   wire rx_last = sync_mode ? (rx_cnt == 4'h7) : (rx_cnt == 4'h9);
   logic [15:0] rx_div;
   logic rx_ph;
   wire rx_div_hit = (rx_div == baud);
   // async sampling restarts at the start edge so each bit is taken mid-cell
   wire rx_tick = sync_mode ? sample_tick : (rx_div_hit && !rx_ph);
   always_ff @(posedge aclk) begin
      if (!aresetn || !rx_busy) begin
         rx_div <= 16'h0000;
         rx_ph <= 1'b0;
      end else begin
         rx_div <= rx_div_hit ? 16'h0000 : rx_div + 16'h0001;
         if (rx_div_hit) rx_ph <= ~rx_ph;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || !rx_run) begin // see R4 see R6
         rx_busy <= 1'b0;
         rx_cnt <= 4'h0;
         rx_sh <= 8'h00;
         rx_buf <= 8'h00;
         rx_full <= 1'b0;
         frame_err <= 1'b0;
         overrun <= 1'b0;
         rx_ev <= 1'b0;
         err_ev <= 1'b0;
      end else begin
         rx_ev <= 1'b0;
         err_ev <= 1'b0;
         if (rd_rxbuf) rx_full <= 1'b0;
         if (!rx_busy && (sync_mode || !rxd_d)) begin
            rx_busy <= 1'b1;
            rx_cnt <= 4'h0;
         end else if (rx_busy && rx_tick) begin
            rx_cnt <= rx_cnt + 4'h1;
            if (sync_mode || (rx_cnt != 4'h0 && !rx_last)) rx_sh <= {rxd_d, rx_sh[7:1]};
            if (rx_last) begin
               rx_busy <= 1'b0;
               rx_buf <= sync_mode ? {rxd_d, rx_sh[7:1]} : rx_sh;
               rx_full <= 1'b1;
               rx_ev <= 1'b1;
               overrun <= rx_full && !rd_rxbuf;
               frame_err <= !sync_mode && !rxd_d;
               err_ev <= (rx_full && !rd_rxbuf) || (!sync_mode && !rxd_d);
            end
         end
      end
   end
   // transmit request on rising edge of the chosen flag (see R10)
   logic tx_src_d;
   // gated by tx_en so that setting it shows as a rising flag (see R11)
   wire tx_src = tx_en && (ctrl[sio_pkg::CTRL_TXI_SRC] ? tx_done : tx_empty);
   wire tx_ev = tx_src && !tx_src_d;
   wire irq_clr_wr = wr_fire && aw_addr == sio_pkg::ADDR_IRQ_CLR && w_strb[0];
   wire [2:0] irq_clr = irq_clr_wr ? w_data[2:0] : 3'h0;
   wire [2:0] irq_set = {err_ev, rx_ev, tx_ev};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_src_d <= 1'b0;
         irq_stat <= 3'h0;
      end else begin
         tx_src_d <= tx_src;
         // set wins over a clear in the same cycle
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      end
   end
   assign irq = |(irq_stat & irq_en);
   // axi read path
   logic [31:0] rd_mux;
   wire [7:0] ar_addr = {s_axi_araddr[7:2], 2'b00};
   wire rd_fire = s_axi_arvalid && s_axi_arready;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_rxbuf = rd_fire && ar_addr == sio_pkg::ADDR_RXBUF;
   wire rd_known = ar_addr inside {sio_pkg::ADDR_CTRL, sio_pkg::ADDR_STATUS, sio_pkg::ADDR_RXBUF,
                                   sio_pkg::ADDR_BAUD, sio_pkg::ADDR_IRQ_STAT, sio_pkg::ADDR_IRQ_EN};
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (ar_addr)
         sio_pkg::ADDR_CTRL: rd_mux = {25'h0, ctrl};
         sio_pkg::ADDR_STATUS: rd_mux = {27'h0, overrun, frame_err, rx_full, tx_done, tx_empty};
         sio_pkg::ADDR_RXBUF: rd_mux = {24'h0, rx_buf};
         sio_pkg::ADDR_BAUD: rd_mux = {16'h0, baud};
         sio_pkg::ADDR_IRQ_STAT: rd_mux = {29'h0, irq_stat};
         sio_pkg::ADDR_IRQ_EN: rd_mux = {29'h0, irq_en};
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= sio_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_known ? sio_pkg::RESP_OKAY : sio_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // pins: unit enable gates only the pins, never the shifter (see R1)
   assign txd_out = tx_line;
   assign txd_oe = sio_en;
   assign sclk_out = int_clk;
   assign sclk_oe = sio_en && sync_mode && !ext_clk && tx_en;
   // ready output needs receive, ready and transmit enables together (see R5)
   wire rdy_drive = sio_en && sync_mode && ctrl[sio_pkg::CTRL_RDY_EN] && rx_en && tx_en;
   assign receiver_ready_pin_oe = rdy_drive;
   assign receiver_ready_pin_n = !(rdy_drive && !rx_full);
endmodule // sio_top

// ===== common/sio_pkg.sv
package sio_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TXBUF = 8'h08;
   localparam logic [7:0] ADDR_RXBUF = 8'h0C;
   localparam logic [7:0] ADDR_BAUD = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h1C;
   // control fields
   localparam int CTRL_TX_EN = 0;
   localparam int CTRL_RX_EN = 1;
   localparam int CTRL_SIO_EN = 2;
   localparam int CTRL_SYNC = 3;
   localparam int CTRL_EXT_CLK = 4;
   localparam int CTRL_RDY_EN = 5;
   localparam int CTRL_TXI_SRC = 6;
   localparam int CTRL_W = 7;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   // status fields
   localparam int ST_TX_EMPTY = 0;
   localparam int ST_TX_DONE = 1;
   localparam int ST_RX_FULL = 2;
   localparam int ST_FRAME_ERR = 3;
   localparam int ST_OVERRUN = 4;
   // interrupt fields
   localparam int IRQ_TX = 0;
   localparam int IRQ_RX = 1;
   localparam int IRQ_ERR = 2;
   localparam int IRQ_W = 3;
   localparam logic [15:0] BAUD_RESET = 16'h0013;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/sio_tx.sv
`timescale 1ns/100ps
module sio_tx (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic tx_en,
   input wire logic sync_mode,
   input wire logic shift_tick,
   input wire logic half_tick,
   input wire logic load,
   input wire logic [7:0] load_data,
   // status
   output logic buf_empty,
   output logic shift_done,
   output logic tx_line
);
   typedef enum logic [1:0] {
      SIO_TX_IDLE = 2'b00,
      SIO_TX_WAIT = 2'b01,
      SIO_TX_ARM = 2'b11,
      SIO_TX_SHIFT = 2'b10
   } sio_tx_state_t;
   sio_tx_state_t state;
   logic [7:0] hold;
   logic [9:0] shreg;
   logic [3:0] bits;
   wire [3:0] frame_bits = sync_mode ? 4'h8 : 4'hA;
   wire [9:0] frame = sync_mode ? {2'b11, hold} : {1'b1, hold, 1'b0};
   // internal shifting never looks at the pin enable, only aresetn and tx_en reset it
   always_ff @(posedge aclk) begin
      if (!aresetn || !tx_en) begin
         state <= SIO_TX_IDLE;
         buf_empty <= 1'b1;
         shift_done <= 1'b1;
         shreg <= 10'h3FF;
         bits <= 4'h0;
         hold <= 8'h00;
      end else begin
         if (load) begin
            hold <= load_data;
            buf_empty <= 1'b0;
         end
         unique case (state)
            SIO_TX_IDLE: if (load) state <= SIO_TX_WAIT;
            // with the internal clock a half-clock edge must pass first, so done never falls sooner than half a shift clock
            SIO_TX_WAIT: if (half_tick) state <= SIO_TX_ARM; // see R7
            SIO_TX_ARM: if (shift_tick) begin
               // done falls 0.5..1.5 shift clocks after the write with the internal clock, at the next sclk fall with the external one (see R7)
               shreg <= frame;
               bits <= frame_bits;
               buf_empty <= 1'b1;
               shift_done <= 1'b0;
               state <= SIO_TX_SHIFT;
            end
            SIO_TX_SHIFT: if (shift_tick) begin
               shreg <= {1'b1, shreg[9:1]};
               bits <= bits - 4'h1;
               if (bits == 4'h1) begin
                  if (!buf_empty) begin
                     shreg <= frame;
                     bits <= frame_bits;
                     buf_empty <= 1'b1;
                  end else begin
                     shift_done <= 1'b1;
                     state <= SIO_TX_IDLE;
                  end
               end
            end
         endcase
         if (load && state == SIO_TX_IDLE) shift_done <= 1'b1;
      end
   end
   assign tx_line = (state == SIO_TX_SHIFT) ? shreg[0] : 1'b1;
endmodule // sio_tx

// ===== sim/sio_checker.sv
`timescale 1ns/100ps
module sio_checker (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins
   input wire logic txd_out,
   input wire logic txd_oe,
   input wire logic sclk_oe,
   input wire logic receiver_ready_pin_n,
   input wire logic receiver_ready_pin_oe,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_b_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   // the shifter must come out of reset idle and undriven
   a_reset_idle: assert property ($rose(aresetn) |-> txd_out && !txd_oe && !irq)
      else $error("not idle after reset");
   a_pins_free: assert property (!txd_oe |-> !sclk_oe && !receiver_ready_pin_oe)
      else $error("pin driven while unit off");
   a_rdy_idle: assert property (!receiver_ready_pin_oe |-> receiver_ready_pin_n)
      else $error("ready pin active while undriven");
endmodule // sio_checker

// ===== sim/sio_far.sv
`timescale 1ns/100ps
module sio_far #(
   parameter int BIT_NS = 1000
) (
   // serial lines
   input wire logic txd_out,
   output logic rxd_in,
   output logic sclk_in
);
   // clock stands high between frames so enables and loads land safely
   initial begin
      rxd_in = 1'b1;
      sclk_in = 1'b1;
   end
   task automatic send(input logic [7:0] b);
      rxd_in = 1'b0;
      #(BIT_NS);
      for (int k = 0; k < 9; k++) begin
         rxd_in = (k == 8) ? 1'b1 : b[k];
         #(BIT_NS);
      end
   endtask
   // gives up on a silent line and returns the idle ones
   task automatic take(output logic [7:0] b);
      int i;
      for (i = 0; i < 4000 && txd_out; i++) #5;
      #(BIT_NS * 3 / 2);
      for (int k = 0; k < 8; k++) begin
         b[k] = txd_out;
         #(BIT_NS);
      end
   endtask
   task automatic swap(input logic [7:0] o, output logic [7:0] b);
      for (int k = 0; k < 8; k++) begin
         sclk_in = 1'b0;
         rxd_in = o[k];
         #100;
         sclk_in = 1'b1;
         #95;
         b[k] = txd_out;
         #5;
      end
      rxd_in = ~o[7];
   endtask
endmodule // sio_far

// ===== sim/tb.sv
`timescale 1ns/100ps
module tb;
   localparam int BT = 2 * (sio_pkg::BAUD_RESET + 1);
   logic aclk = 1'b0;
   logic aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic txd_out, txd_oe, rxd_in, sclk_in, sclk_out, sclk_oe, receiver_ready_pin_n, receiver_ready_pin_oe, irq;
   logic [7:0] b;
   int n_fail, checked;
   always #12.5 aclk = ~aclk;
   sio_top DUT (.*);
   sio_far #(.BIT_NS(BT * 25)) u_far (.txd_out(txd_out), .rxd_in(rxd_in), .sclk_in(sclk_in));
   task automatic end_of_test();
      $display("checks %0d fails %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic tmo();
      n_fail++;
      end_of_test();
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (i == 50) tmo();
   endtask
   task automatic rd(input logic [7:0] a);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (i == 50) tmo();
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
      rd(a);
      chk(nm, d & m, e);
   endtask
   // waits on receive-full, long enough for one whole frame
   task automatic pl();
      int i;
      for (i = 0; i < 400; i++) begin
         rd(sio_pkg::ADDR_STATUS);
         if (d[sio_pkg::ST_RX_FULL] === 1'b1) break;
      end
      if (i == 400) tmo();
   endtask
   task automatic t_regs();
      rc("ctrl", sio_pkg::ADDR_CTRL, 32'h7F, 32'h00);
      rc("baud", sio_pkg::ADDR_BAUD, 32'hFFFF, {16'h0000, sio_pkg::BAUD_RESET});
      rd(8'h20);
      chk("resp", {30'h0, r}, {30'h0, sio_pkg::RESP_SLVERR});
      wr(8'h24, 32'h0);
      chk("bresp", {30'h0, r}, {30'h0, sio_pkg::RESP_SLVERR});
      $display("regs done");
   endtask
   task automatic t_txen();
      wr(sio_pkg::ADDR_CTRL, 32'h05);
      rc("flags", sio_pkg::ADDR_STATUS, 32'h03, 32'h03);
      rc("txreq", sio_pkg::ADDR_IRQ_STAT, 32'h01, 32'h01);
      chk("mask", irq, 1'b0);
      wr(sio_pkg::ADDR_IRQ_CLR, 32'h01);
      wr(sio_pkg::ADDR_IRQ_EN, 32'h01);
      chk("irq", irq, 1'b0);
      $display("txen done");
   endtask
   task automatic t_atx();
      wr(sio_pkg::ADDR_TXBUF, 32'hA5);
      rc("early", sio_pkg::ADDR_STATUS, 32'h02, 32'h02);
      u_far.take(b);
      chk("txbyte", b, 8'hA5);
      chk("irq", irq, 1'b1);
      wr(sio_pkg::ADDR_IRQ_CLR, 32'h01);
      chk("clr", irq, 1'b0);
      $display("async tx done");
   endtask
   task automatic t_rx();
      wr(sio_pkg::ADDR_CTRL, 32'h06);
      u_far.send(8'h3C);
      pl();
      rc("rxbyte", sio_pkg::ADDR_RXBUF, 32'hFF, 32'h3C);
      chk("txidle", txd_out, 1'b1);
      $display("rx done");
   endtask
   task automatic t_off();
      wr(sio_pkg::ADDR_CTRL, 32'h00);
      wr(sio_pkg::ADDR_CTRL, 32'h01);
      wr(sio_pkg::ADDR_TXBUF, 32'h5A);
      chk("oe", txd_oe, 1'b0);
      repeat (2 * BT) @(posedge aclk);
      rc("late", sio_pkg::ADDR_STATUS, 32'h02, 32'h00);
      repeat (11 * BT) @(posedge aclk);
      rc("shifted", sio_pkg::ADDR_STATUS, 32'h02, 32'h02);
      $display("unit off done");
   endtask
   task automatic t_abort();
      wr(sio_pkg::ADDR_CTRL, 32'h05);
      wr(sio_pkg::ADDR_TXBUF, 32'h00);
      repeat (3 * BT) @(posedge aclk);
      chk("low", txd_out, 1'b0);
      wr(sio_pkg::ADDR_CTRL, 32'h04);
      @(posedge aclk);
      chk("idle", txd_out, 1'b1);
      $display("abort done");
   endtask
   task automatic t_sync();
      wr(sio_pkg::ADDR_CTRL, 32'h3F);
      chk("rdy", {receiver_ready_pin_oe, receiver_ready_pin_n}, 2'b10);
      wr(sio_pkg::ADDR_TXBUF, 32'h96);
      u_far.swap(8'h69, b);
      chk("stx", b, 8'h96);
      pl();
      rc("srx", sio_pkg::ADDR_RXBUF, 32'hFF, 32'h69);
      wr(sio_pkg::ADDR_CTRL, 32'h00);
      chk("rdyoff", receiver_ready_pin_oe, 1'b0);
      $display("sync done");
   endtask
   initial begin
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_txen();
      t_atx();
      t_rx();
      t_off();
      t_abort();
      t_sync();
      end_of_test();
   end
endmodule // tb
bind sio_top sio_checker u_chk (.*);
